// [rtl/mpsr_defines.svh]
`ifndef MPSR_DEFINES_SVH
`define MPSR_DEFINES_SVH

// Register indices; byte address is four times the index
`define MPSR_IDX_CRC_CFG 8'hC1
`define MPSR_IDX_MEM_CTRL 8'hC6
`define MPSR_IDX_RANGE_CTRL 8'hD8
`define MPSR_IDX_PSW 8'hD0

// Boot check configuration fields
`define MPSR_CRC_RANGE_HI 7
`define MPSR_CRC_RANGE_LO 4
`define MPSR_CRC_MODEM_BIT 1
`define MPSR_CRC_EN_BIT 0

// Memory control fields, both variants
`define MPSR_PA_HI 7
`define MPSR_PA_LO 4
`define MPSR_MC_BIT3 3
`define MPSR_MC_BIT2 2
`define MPSR_MC_BIT1 1
`define MPSR_SL_BIT 0

// Range and override control fields
`define MPSR_AE_BIT 4
`define MPSR_RG0_BIT 0

// Program status word parity position
`define MPSR_PSW_PARITY_BIT 0

// Reset and forced values
`define MPSR_PA_ALL_ONES 4'hF
`define MPSR_PA_ZERO 4'h0
`define MPSR_BYTE_ZERO 8'h00

// Address arithmetic
`define MPSR_PA_STEP 16'h0800
`define MPSR_PA_CODE_E_ADDR 16'h7000
`define MPSR_PA_CODE_F_ADDR 16'h8000
`define MPSR_CRC_STEP_SHIFT 12
`define MPSR_RANGE_8K 16'h1FFF
`define MPSR_RANGE_32K 16'h7FFF
`define MPSR_OVERRIDE_BOUNDARY 16'h1000

`endif

// [rtl/mpsr_pkg.sv]
`default_nettype none
package mpsr_pkg;

  typedef enum logic [2:0] {
    MPSR_CRC_IDLE = 3'b001,
    MPSR_CRC_CHECK = 3'b010,
    MPSR_CRC_DONE = 3'b100
  } mpsr_crc_state_t;

  typedef struct packed {
    logic [3:0] crc_range_field;
    logic modem_fallback;
    logic crc_enable;
    logic [3:0] partition_code;
    logic range_size_select;
    logic second_enable_control;
    logic partition_write_unlock;
    logic security_lock;
    logic program_range_upper;
    logic peripheral_enable_select;
    logic partition_mode;
    logic program_range_lower;
    logic access_enable_override;
    logic loader_zeroed;
    logic [7:0] program_status_word;
    logic ack;
    logic [7:0] rdata;
    mpsr_crc_state_t crc_state;
    logic crc_fail;
    logic modem_attempt;
    logic [3:0] peripheral_strobes;
    logic data_chip_enable_two;
  } mpsr_state_t;

endpackage : mpsr_pkg
`default_nettype wire

// [rtl/mpsr_top.sv]
// Overview of operation
// - Upper nibble of boot check config gives CRC extent in 4K steps.
// - CRC range readable always; written only over the loader path.
// - Modem fallback tried on CRC failure; bit writable only in load mode.
// - CRC enable runs check at power-up and watchdog; mismatch forces load mode.
// - Backup-loss reset clears all CRC config bits; program lies below partition.
// - Partition code maps in 0800H steps; 1110 gives 7000H, 1111 gives 8000H.
// - Code forced to ones on backup loss, lock clearing, or zeroing while locked.
// - Partition code writes need unlock bit set; no timed access then.
// - Range size bit picks highest bus address 1FFFH or 7FFFH.
// - Range size set on backup loss or lock clear; kept otherwise; loader only.
// - Second enable control writable always; cleared only by backup loss.
// - Partition write unlock clears on any reset; writable only by timed access.
// - Security lock reads 1 locked; changed by loader lock/unlock commands, cleared by backup loss.
// - Second variant code marks boundary in mode 0; ones on backup loss.
// - Second variant loader zero write while locked becomes ones; also on unlock.
// - Second variant app writes timed, refused after loader zero; zero becomes ones.
// - Upper program range bit pairs with lower bit; set on loss or unlock; loader.
// - Peripheral select drives four strobes, 16K blocks; clears on any reset.
// - Partition mode 0 continuous, 1 fixed; clears on backup loss; loader only.
// - Status word clears on any reset; parity read-only, others read/write.
// - Access override forces partitionable map at 4K; prior map back on clear.
//
// Decided for this implementation: the Wishbone interface to the registers.
`include "mpsr_defines.svh"
`default_nettype none

module mpsr_top #(
  parameter bit SECOND_VARIANT = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic backup_loss_rst_i,
  input wire logic watchdog_rst_i,
  input wire logic external_rst_i,
  input wire logic powerup_rst_i,
  input wire logic loader_priv_i,
  input wire logic program_load_mode_i,
  input wire logic timed_access_i,
  input wire logic lock_cmd_i,
  input wire logic unlock_cmd_i,
  input wire logic crc_done_i,
  input wire logic crc_match_i,
  input wire logic acc_parity_i,
  input wire logic external_data_move_i,
  input wire logic [15:0] external_addr_i,
  output logic crc_check_req_o,
  output logic [15:0] crc_range_end_o,
  output logic force_load_mode_o,
  output logic modem_attempt_o,
  output logic [15:0] data_start_addr_o,
  output logic [15:0] max_bus_addr_o,
  output logic partitionable_map_o,
  output logic [1:0] program_range_o,
  output logic [3:0] peripheral_strobes_o,
  output logic data_chip_enable_two_o,
  output logic security_lock_o
);
  import mpsr_pkg::*;

  mpsr_state_t s;
  mpsr_state_t next_s;

  // Partition code to data start address
  function automatic logic [15:0] partition_to_addr(input logic [3:0] code);
    logic [15:0] addr;
    addr = 16'h0000;
    if (code == 4'hE) begin
      addr = `MPSR_PA_CODE_E_ADDR;
    end else if (code == 4'hF) begin
      addr = `MPSR_PA_CODE_F_ADDR;
    end else begin
      addr = 16'(code) * `MPSR_PA_STEP;
    end
    return addr;
  endfunction

  logic any_reset;
  logic req;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic lock_clear;
  logic [3:0] wr_pa;
  logic [7:0] rd_mux;

  assign any_reset = backup_loss_rst_i | watchdog_rst_i | external_rst_i | powerup_rst_i;
  assign req = wb_cyc_i & wb_stb_i & ~s.ack;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign idx = wb_adr_i[9:2];
  assign wbyte = wb_dat_i[7:0];
  assign wr_pa = wbyte[`MPSR_PA_HI:`MPSR_PA_LO];
  assign lock_clear = unlock_cmd_i & s.security_lock & ~lock_cmd_i;

  always_comb begin
    rd_mux = `MPSR_BYTE_ZERO;
    if (idx == `MPSR_IDX_CRC_CFG) begin
      rd_mux = {s.crc_range_field, 2'b00, s.modem_fallback, s.crc_enable};
    end else if (idx == `MPSR_IDX_MEM_CTRL) begin
      if (SECOND_VARIANT) begin
        rd_mux = {s.partition_code, s.program_range_upper, s.peripheral_enable_select,
                  s.partition_mode, s.security_lock};
      end else begin
        rd_mux = {s.partition_code, s.range_size_select, s.second_enable_control,
                  s.partition_write_unlock, s.security_lock};
      end
    end else if (idx == `MPSR_IDX_RANGE_CTRL && SECOND_VARIANT) begin
      rd_mux = {3'b000, s.access_enable_override, 3'b000, s.program_range_lower};
    end else if (idx == `MPSR_IDX_PSW) begin
      rd_mux = s.program_status_word;
    end
  end

  always_comb begin
    next_s = s;
    next_s.ack = req;
    next_s.crc_fail = 1'b0;
    if (req) begin
      next_s.rdata = wb_we_i ? `MPSR_BYTE_ZERO : rd_mux;
    end

    // Boot check configuration
    if (wr && idx == `MPSR_IDX_CRC_CFG) begin
      if (loader_priv_i) begin
        next_s.crc_range_field = wbyte[`MPSR_CRC_RANGE_HI:`MPSR_CRC_RANGE_LO];
      end
      if (program_load_mode_i) begin
        next_s.modem_fallback = wbyte[`MPSR_CRC_MODEM_BIT];
        next_s.crc_enable = wbyte[`MPSR_CRC_EN_BIT];
      end
    end

    // Memory control writes
    if (wr && idx == `MPSR_IDX_MEM_CTRL) begin
      if (SECOND_VARIANT) begin
        if (loader_priv_i) begin
          if (wr_pa == `MPSR_PA_ZERO && s.security_lock) begin
            next_s.partition_code = `MPSR_PA_ALL_ONES;
            next_s.loader_zeroed = 1'b0;
          end else begin
            next_s.partition_code = wr_pa;
            next_s.loader_zeroed = (wr_pa == `MPSR_PA_ZERO);
          end
          next_s.program_range_upper = wbyte[`MPSR_MC_BIT3];
          next_s.partition_mode = wbyte[`MPSR_MC_BIT1];
        end else if (timed_access_i && !s.loader_zeroed) begin
          if (wr_pa == `MPSR_PA_ZERO) begin
            next_s.partition_code = `MPSR_PA_ALL_ONES;
          end else begin
            next_s.partition_code = wr_pa;
          end
        end
        next_s.peripheral_enable_select = wbyte[`MPSR_MC_BIT2];
      end else begin
        if (s.partition_write_unlock) begin
          if (wr_pa == `MPSR_PA_ZERO && s.security_lock) begin
            next_s.partition_code = `MPSR_PA_ALL_ONES;
          end else begin
            next_s.partition_code = wr_pa;
          end
        end
        if (loader_priv_i) begin
          next_s.range_size_select = wbyte[`MPSR_MC_BIT3];
        end
        next_s.second_enable_control = wbyte[`MPSR_MC_BIT2];
        if (timed_access_i) begin
          next_s.partition_write_unlock = wbyte[`MPSR_MC_BIT1];
        end
      end
    end

    // Range and override control, second variant only
    if (SECOND_VARIANT && wr && idx == `MPSR_IDX_RANGE_CTRL) begin
      if (timed_access_i) begin
        next_s.access_enable_override = wbyte[`MPSR_AE_BIT];
      end
      if (loader_priv_i) begin
        next_s.program_range_lower = wbyte[`MPSR_RG0_BIT];
      end
    end

    // Status word: parity follows the accumulator, other bits by software
    next_s.program_status_word[`MPSR_PSW_PARITY_BIT] = acc_parity_i;
    if (wr && idx == `MPSR_IDX_PSW) begin
      next_s.program_status_word[7:1] = wbyte[7:1];
    end

    // Lock commands from the loader only
    if (lock_cmd_i) begin
      next_s.security_lock = 1'b1;
    end else if (unlock_cmd_i) begin
      next_s.security_lock = 1'b0;
    end
    if (lock_clear) begin
      next_s.partition_code = `MPSR_PA_ALL_ONES;
      next_s.loader_zeroed = 1'b0;
      next_s.range_size_select = 1'b1;
      next_s.program_range_upper = 1'b1;
      next_s.program_range_lower = 1'b0;
    end

    // Boot check sequencer
    unique case (s.crc_state)
      MPSR_CRC_IDLE: begin
        if ((powerup_rst_i | watchdog_rst_i) && s.crc_enable) begin
          next_s.crc_state = MPSR_CRC_CHECK;
        end
      end
      MPSR_CRC_CHECK: begin
        if (crc_done_i) begin
          next_s.crc_state = MPSR_CRC_DONE;
          next_s.crc_fail = ~crc_match_i;
          next_s.modem_attempt = ~crc_match_i & s.modem_fallback;
        end
      end
      MPSR_CRC_DONE: begin
        next_s.crc_state = MPSR_CRC_IDLE;
      end
      default: begin
        next_s.crc_state = MPSR_CRC_IDLE;
      end
    endcase

    // External data moves
    next_s.peripheral_strobes = 4'h0;
    if (s.peripheral_enable_select && external_data_move_i) begin
      next_s.peripheral_strobes[external_addr_i[15:14]] = 1'b1;
    end
    next_s.data_chip_enable_two = s.second_enable_control & external_data_move_i &
                                  ~s.peripheral_enable_select;

    // Resets of every kind
    if (any_reset) begin
      next_s.partition_write_unlock = 1'b0;
      next_s.peripheral_enable_select = 1'b0;
      next_s.access_enable_override = 1'b0;
      next_s.program_status_word = `MPSR_BYTE_ZERO;
      next_s.peripheral_strobes = 4'h0;
      next_s.data_chip_enable_two = 1'b0;
      next_s.modem_attempt = 1'b0;
    end
    if (backup_loss_rst_i) begin
      next_s.crc_range_field = 4'h0;
      next_s.modem_fallback = 1'b0;
      next_s.crc_enable = 1'b0;
      next_s.partition_code = `MPSR_PA_ALL_ONES;
      next_s.loader_zeroed = 1'b0;
      next_s.range_size_select = 1'b1;
      next_s.second_enable_control = 1'b0;
      next_s.security_lock = 1'b0;
      next_s.program_range_upper = 1'b1;
      next_s.partition_mode = 1'b0;
      next_s.program_range_lower = 1'b0;
      next_s.crc_state = MPSR_CRC_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.partition_code <= `MPSR_PA_ALL_ONES;
      s.range_size_select <= 1'b1;
      s.program_range_upper <= 1'b1;
      s.crc_state <= MPSR_CRC_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_o = s.ack;
  assign wb_dat_o = {24'h000000, s.rdata};
  assign crc_check_req_o = (s.crc_state == MPSR_CRC_CHECK);
  assign crc_range_end_o = 16'({s.crc_range_field, 12'h000});
  assign force_load_mode_o = s.crc_fail;
  assign modem_attempt_o = s.modem_attempt;
  assign max_bus_addr_o = s.range_size_select ? `MPSR_RANGE_32K : `MPSR_RANGE_8K;
  assign program_range_o = {s.program_range_upper, s.program_range_lower};
  assign peripheral_strobes_o = s.peripheral_strobes;
  assign data_chip_enable_two_o = s.data_chip_enable_two;
  assign security_lock_o = s.security_lock;

  always_comb begin
    data_start_addr_o = partition_to_addr(s.partition_code);
    partitionable_map_o = 1'b1;
    if (SECOND_VARIANT) begin
      partitionable_map_o = ~s.partition_mode | s.access_enable_override;
      if (s.access_enable_override) begin
        data_start_addr_o = `MPSR_OVERRIDE_BOUNDARY;
      end
    end
  end

endmodule // mpsr_top
`default_nettype wire

// [test/mpsr_top_assertions.sv]
`default_nettype none
module mpsr_chk #(
  parameter bit SECOND_VARIANT = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic backup_loss_rst_i,
  input wire logic watchdog_rst_i,
  input wire logic powerup_rst_i,
  input wire logic lock_cmd_i,
  input wire logic unlock_cmd_i,
  input wire logic crc_done_i,
  input wire logic crc_match_i,
  input wire logic crc_check_req_o,
  input wire logic [15:0] crc_range_end_o,
  input wire logic force_load_mode_o,
  input wire logic modem_attempt_o,
  input wire logic [15:0] data_start_addr_o,
  input wire logic [15:0] max_bus_addr_o,
  input wire logic [1:0] program_range_o,
  input wire logic security_lock_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_pulse_only: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  chk_ack_next_edge: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered on the next edge");
  chk_crc_range_align: assert property (crc_range_end_o[11:0] == 12'h000)
    else $error("check range end not on a 4K step");
  chk_crc_req_cause: assert property ($rose(crc_check_req_o) |-> $past(powerup_rst_i || watchdog_rst_i))
    else $error("check request without power-up or watchdog event");
  chk_force_load_cause: assert property (force_load_mode_o |->
    $past(crc_done_i && !crc_match_i && crc_check_req_o) ##1 !force_load_mode_o)
    else $error("load mode forced without a failed check");
  chk_modem_try_cause: assert property ($rose(modem_attempt_o) |-> $past(crc_done_i && !crc_match_i))
    else $error("modem attempt without a failed check");
  chk_lock_cmd_sets: assert property (lock_cmd_i && !backup_loss_rst_i |=> security_lock_o)
    else $error("lock command did not set the lock");
  chk_lock_holds_still: assert property (!lock_cmd_i && !unlock_cmd_i && !backup_loss_rst_i |=>
    $stable(security_lock_o))
    else $error("lock changed without a loader command");
  chk_unlock_restores: assert property (!SECOND_VARIANT && security_lock_o && unlock_cmd_i && !lock_cmd_i |=>
    data_start_addr_o == 16'h8000 && max_bus_addr_o == 16'h7FFF && program_range_o[1])
    else $error("lock clearing did not restore map defaults");
  chk_backup_defaults: assert property (!SECOND_VARIANT && backup_loss_rst_i |=>
    data_start_addr_o == 16'h8000 && max_bus_addr_o == 16'h7FFF && !security_lock_o && crc_range_end_o == 16'h0000)
    else $error("backup loss reset left wrong values");
  cover property (force_load_mode_o && modem_attempt_o);
  cover property ($rose(security_lock_o));
  cover property (max_bus_addr_o == 16'h1FFF);
endmodule // mpsr_chk
bind mpsr_top mpsr_chk #(.SECOND_VARIANT(SECOND_VARIANT)) u_mpsr_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .backup_loss_rst_i(backup_loss_rst_i),
  .watchdog_rst_i(watchdog_rst_i), .powerup_rst_i(powerup_rst_i), .lock_cmd_i(lock_cmd_i),
  .unlock_cmd_i(unlock_cmd_i), .crc_done_i(crc_done_i), .crc_match_i(crc_match_i),
  .crc_check_req_o(crc_check_req_o), .crc_range_end_o(crc_range_end_o), .force_load_mode_o(force_load_mode_o),
  .modem_attempt_o(modem_attempt_o), .data_start_addr_o(data_start_addr_o), .max_bus_addr_o(max_bus_addr_o),
  .program_range_o(program_range_o), .security_lock_o(security_lock_o));
`default_nettype wire

// [test/tb.sv]
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CFG = 32'h0000_0304;
  localparam logic [31:0] MC = 32'h0000_0318;
  localparam logic [31:0] PROGRAM_STATUS_WORD = 32'h0000_0340;
  localparam logic [31:0] OVR = 32'h0000_0360;
  logic clk_i, rst_i, cyc, stb, we, priv, lm, ta, done, match, par, move, ack, req, force_lm, modem, dce2, lock;
  logic [31:0] adr, wdat, rdat;
  logic [3:0] sel;
  logic [5:0] ev;
  logic [15:0] crc_end, dstart, maxa;
  logic [15:0] dstart2, xadr;
  logic [31:0] rdat2;
  logic [7:0] q2;
  logic [3:0] strb2;
  logic [1:0] prange2;
  logic map2;
  int failures, checked, cycles;
  mpsr_top u_mpsr_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .backup_loss_rst_i(ev[0]), .watchdog_rst_i(ev[1]), .external_rst_i(ev[2]), .powerup_rst_i(ev[3]),
    .loader_priv_i(priv), .program_load_mode_i(lm), .timed_access_i(ta), .lock_cmd_i(ev[4]),
    .unlock_cmd_i(ev[5]), .crc_done_i(done), .crc_match_i(match), .acc_parity_i(par),
    .external_data_move_i(move), .external_addr_i(xadr), .crc_check_req_o(req), .crc_range_end_o(crc_end),
    .force_load_mode_o(force_lm), .modem_attempt_o(modem), .data_start_addr_o(dstart), .max_bus_addr_o(maxa),
    .partitionable_map_o(), .program_range_o(), .peripheral_strobes_o(), .data_chip_enable_two_o(dce2),
    .security_lock_o(lock));
  // Second memory-control layout, fed from the same bus and events as the first
  if (1'b1) begin : g_second
    mpsr_top #(.SECOND_VARIANT(1'b1)) u_mpsr_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat2), .wb_ack_o(),
      .backup_loss_rst_i(ev[0]), .watchdog_rst_i(ev[1]), .external_rst_i(ev[2]), .powerup_rst_i(ev[3]),
      .loader_priv_i(priv), .program_load_mode_i(lm), .timed_access_i(ta), .lock_cmd_i(ev[4]),
      .unlock_cmd_i(ev[5]), .crc_done_i(done), .crc_match_i(match), .acc_parity_i(par),
      .external_data_move_i(move), .external_addr_i(xadr), .crc_check_req_o(), .crc_range_end_o(),
      .force_load_mode_o(), .modem_attempt_o(), .data_start_addr_o(dstart2), .max_bus_addr_o(),
      .partitionable_map_o(map2), .program_range_o(prange2), .peripheral_strobes_o(strb2),
      .data_chip_enable_two_o(), .security_lock_o());
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask
  // Classic single cycle: hold everything until ack is sampled high
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    q2 = rdat2[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [31:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check(nm, {8'h00, e}, {8'h00, q});
  endtask
  task automatic rd2(input string nm, input logic [31:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check(nm, {8'h00, e}, {8'h00, q2});
  endtask
  task automatic pulse(input int b);
    @(posedge clk_i);
    ev[b] <= 1'b1;
    @(posedge clk_i);
    ev[b] <= 1'b0;
  endtask
  task automatic wait_high(input string nm, ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 8) begin
      @(posedge clk_i);
      n++;
    end
    check(nm, 16'h0001, {15'h0000, s});
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    {cyc, stb, we, priv, lm, ta, done, match, par, move} = '0;
    adr = '0;
    wdat = '0;
    sel = 4'hF;
    ev = '0;
    xadr = '0;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("boot config", CFG, 8'h00);
    rd("mem control", MC, 8'hF8);
    rd("status word", PROGRAM_STATUS_WORD, 8'h00);
    rd("unmapped", 32'h0000_03FC, 8'h00);
    check("max address", 16'h7FFF, maxa);
    $display("test reset values done");
    wr(CFG, 8'h53);
    rd("boot config app", CFG, 8'h00);
    priv <= 1'b1;
    lm <= 1'b1;
    wr(CFG, 8'h53);
    priv <= 1'b0;
    lm <= 1'b0;
    rd("boot config loader", CFG, 8'h53);
    check("range end", 16'h5000, crc_end);
    pulse(3);
    wait_high("check request", req);
    @(posedge clk_i);
    done <= 1'b1;
    @(posedge clk_i);
    done <= 1'b0;
    wait_high("forced load", force_lm);
    check("modem attempt", 16'h0001, {15'h0000, modem});
    rd("config kept", CFG, 8'h53);
    $display("test boot check done");
    wr(MC, 8'h08);
    rd("code locked out", MC, 8'hF8);
    ta <= 1'b1;
    wr(MC, 8'hFA);
    ta <= 1'b0;
    rd("unlock bit", MC, 8'hFA);
    for (int i = 0; i < 16; i++) begin
      wr(MC, {i[3:0], 4'hA});
      rd("code written", MC, {i[3:0], 4'hA});
      check("data start", i == 15 ? 16'h8000 : i == 14 ? 16'h7000 : 16'(i) * 16'h0800, dstart);
    end
    $display("test partition done");
    priv <= 1'b1;
    wr(MC, 8'hF2);
    priv <= 1'b0;
    check("max address", 16'h1FFF, maxa);
    wr(MC, 8'hFE);
    rd("range kept", MC, 8'hF6);
    @(posedge clk_i);
    move <= 1'b1;
    @(posedge clk_i);
    move <= 1'b0;
    @(posedge clk_i);
    check("chip enable two", 16'h0001, {15'h0000, dce2});
    pulse(1);
    rd("after watchdog", MC, 8'hF4);
    pulse(0);
    rd("after backup loss", MC, 8'hF8);
    rd("config cleared", CFG, 8'h00);
    $display("test resets done");
    pulse(4);
    @(posedge clk_i);
    check("lock", 16'h0001, {15'h0000, lock});
    ta <= 1'b1;
    wr(MC, 8'h02);
    ta <= 1'b0;
    wr(MC, 8'h0A);
    rd("zero while locked", MC, 8'hFB);
    wr(MC, 8'h3A);
    rd("code under lock", MC, 8'h3B);
    pulse(5);
    rd("after unlock", MC, 8'hFA);
    $display("test lock done");
    wr(PROGRAM_STATUS_WORD, 8'hFF);
    rd("status word", PROGRAM_STATUS_WORD, 8'hFE);
    par <= 1'b1;
    rd("parity", PROGRAM_STATUS_WORD, 8'hFF);
    par <= 1'b0;
    pulse(2);
    rd("status cleared", PROGRAM_STATUS_WORD, 8'h00);
    $display("test status word done");
    ta <= 1'b1;
    wr(MC, 8'h34);
    ta <= 1'b0;
    rd2("v2 app code", MC, 8'h3C);
    check("v2 data start", 16'h1800, dstart2);
    @(posedge clk_i);
    move <= 1'b1;
    xadr <= 16'hC000;
    @(posedge clk_i);
    move <= 1'b0;
    @(posedge clk_i);
    check("v2 strobes", 16'h0008, {12'h000, strb2});
    priv <= 1'b1;
    wr(MC, 8'h02);
    priv <= 1'b0;
    check("v2 fixed map", 16'h0000, {15'h0000, map2});
    ta <= 1'b1;
    wr(MC, 8'h50);
    priv <= 1'b1;
    wr(OVR, 8'h11);
    ta <= 1'b0;
    priv <= 1'b0;
    rd2("v2 code refused", MC, 8'h02);
    rd2("v2 range control", OVR, 8'h11);
    check("v2 override start", 16'h1000, dstart2);
    check("v2 override map", 16'h0001, {15'h0000, map2});
    check("v2 program range", 16'h0001, {14'h0000, prange2});
    pulse(4);
    priv <= 1'b1;
    wr(MC, 8'h00);
    priv <= 1'b0;
    rd2("v2 zero under lock", MC, 8'hF1);
    pulse(5);
    rd2("v2 after unlock", MC, 8'hF8);
    check("v2 range after unlock", 16'h0002, {14'h0000, prange2});
    ta <= 1'b1;
    wr(MC, 8'h54);
    ta <= 1'b0;
    pulse(1);
    rd2("v2 code kept", MC, 8'h58);
    check("v2 start restored", 16'h2800, dstart2);
    pulse(0);
    rd2("v2 backup loss", MC, 8'hF8);
    $display("test second variant done");
    end_of_test();
  end
endmodule // tb
`default_nettype wire
